// ===== core/adcc_conv_ctrl.sv
// Converter control top: AXI4-Lite registers, start sequencing,
// conversion timing, result formatting and pin overrides.
// Assumes an analog core that presents a settled 12-bit code on convData.
//
// The AXI4-Lite slave port and the register offsets were decided locally.
module adcc_conv_ctrl (
	input wire logic core_clk, // System clock, 100 MHz
	input wire logic nrst, // Synchronous reset, active low
	input wire logic [7:0] s_axi_awaddr, // Write address
	input wire logic s_axi_awvalid, // Write address valid
	output logic s_axi_awready, // Write address ready
	input wire logic [31:0] s_axi_wdata, // Write data
	input wire logic [3:0] s_axi_wstrb, // Write byte strobes
	input wire logic s_axi_wvalid, // Write data valid
	output logic s_axi_wready, // Write data ready
	output logic [1:0] s_axi_bresp, // Write response
	output logic s_axi_bvalid, // Write response valid
	input wire logic s_axi_bready, // Write response ready
	input wire logic [7:0] s_axi_araddr, // Read address
	input wire logic s_axi_arvalid, // Read address valid
	output logic s_axi_arready, // Read address ready
	output logic [31:0] s_axi_rdata, // Read data
	output logic [1:0] s_axi_rresp, // Read response
	output logic s_axi_rvalid, // Read data valid
	input wire logic s_axi_rready, // Read data ready
	input wire logic subTick, // Sub clock tick
	input wire logic [11:0] convData, // Analog core code
	input wire logic [15:0] pullReq, // Port pull-high settings
	input wire logic [15:0] portDirCtrl, // Port direction, 1 input
	output adcc_pkg::adcc_ana_s anaCtrl, // Analog core controls
	output adcc_pkg::adcc_pin_s pinCtrl, // Pin overrides
	output logic convIrq // Interrupt toward converter vector
);
	import adcc_pkg::*;

	// ==========================================================
	// Register state
	logic startBit; // Start control bit
	logic busy; // conversion_busy_flag
	logic powerDown; // converter_power_down
	logic [4:0] chanSel; // input_channel_select
	logic bandgapEn; // Bandgap circuit enable
	logic justify; // result_justify_select
	logic [1:0] refSel; // reference_source_select
	logic [2:0] divSel; // converter_clock_divider_select
	logic [7:0] pinSelLo; // pin_analog_select_low_group
	logic [7:0] pinSelHi; // pin_analog_select_high_group
	logic gie; // global_interrupt_enable
	logic cie; // converter_interrupt_enable
	logic reqFlag; // Converter interrupt request
	logic [11:0] result; // Latched conversion code

	// ==========================================================
	// Sequencer state
	adcc_state_e state; // Current state
	adcc_state_e next_state; // Following state
	logic [3:0] tickCnt; // Converter clocks elapsed
	logic convTick; // Converter clock enable
	logic convDone; // Last clock of a conversion

	// ==========================================================
	// Write channel
	logic awHeld; // Address captured
	logic wHeld; // Data captured
	logic [7:0] wAddr; // Captured address
	logic [31:0] wData; // Captured data
	logic [3:0] wStrb; // Captured strobes
	logic doWrite; // Both halves present
	logic wLane0; // Low byte lane written
	logic wHit; // Address maps to a register

	assign s_axi_awready = !awHeld && !s_axi_bvalid;
	assign s_axi_wready = !wHeld && !s_axi_bvalid;
	assign doWrite = awHeld && wHeld && !s_axi_bvalid;
	assign wLane0 = doWrite && wStrb[0];
	assign wHit = (wAddr == OFF_CTRL_A) || (wAddr == OFF_CTRL_B) ||
		(wAddr == OFF_RES_LO) || (wAddr == OFF_RES_HI) ||
		(wAddr == OFF_PIN_LO) || (wAddr == OFF_PIN_HI) ||
		(wAddr == OFF_INT);

	// Address and data may arrive in either order
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			awHeld <= 1'b0;
			wHeld <= 1'b0;
			wAddr <= 8'h00;
			wData <= 32'h0000_0000;
			wStrb <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				awHeld <= 1'b1;
				wAddr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wHeld <= 1'b1;
				wData <= s_axi_wdata;
				wStrb <= s_axi_wstrb;
			end
			if (doWrite) begin
				// Both halves consumed, answer next cycle
				awHeld <= 1'b0;
				wHeld <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wHit ? RESP_OKAY : RESP_SLVERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// ==========================================================
	// Result formatting
	logic [7:0] resLo; // Low result byte view
	logic [7:0] resHi; // High result byte view

	// Unused bits fill with zeros in either alignment
	assign resLo = justify ? result[7:0] : {result[3:0], 4'h0};
	assign resHi = justify ? {4'h0, result[11:8]} : result[11:4];

	// ==========================================================
	// Read channel
	logic [7:0] rByte; // Selected register
	logic rHit; // Address maps to a register

	assign rHit = (s_axi_araddr == OFF_CTRL_A) ||
		(s_axi_araddr == OFF_CTRL_B) || (s_axi_araddr == OFF_RES_LO) ||
		(s_axi_araddr == OFF_RES_HI) || (s_axi_araddr == OFF_PIN_LO) ||
		(s_axi_araddr == OFF_PIN_HI) || (s_axi_araddr == OFF_INT);
	assign rByte =
		(s_axi_araddr == OFF_CTRL_A) ?
			{startBit, busy, powerDown, chanSel} :
		(s_axi_araddr == OFF_CTRL_B) ?
			{1'b0, bandgapEn, justify, refSel, divSel} :
		(s_axi_araddr == OFF_RES_LO) ? resLo :
		(s_axi_araddr == OFF_RES_HI) ? resHi :
		(s_axi_araddr == OFF_PIN_LO) ? pinSelLo :
		(s_axi_araddr == OFF_PIN_HI) ? pinSelHi :
		(s_axi_araddr == OFF_INT) ? {5'h00, reqFlag, cie, gie} : 8'h00;
	assign s_axi_arready = !s_axi_rvalid;

	// Data is captured with the address, so it holds while rvalid stands
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= {24'h00_0000, rByte};
			s_axi_rresp <= rHit ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// ==========================================================
	// Control registers; busy is not among the written fields
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			startBit <= RST_CTRL_A[A_START];
			powerDown <= RST_CTRL_A[A_PDOWN];
			chanSel <= RST_CTRL_A[4:0];
			bandgapEn <= RST_CTRL_B[B_BGEN];
			justify <= RST_CTRL_B[B_JUST];
			refSel <= RST_CTRL_B[B_REF_LSB +: 2];
			divSel <= RST_CTRL_B[2:0];
			pinSelLo <= RST_PIN;
			pinSelHi <= RST_PIN;
			gie <= 1'b0;
			cie <= 1'b0;
		end else if (wLane0) begin
			if (wAddr == OFF_CTRL_A) begin
				startBit <= wData[A_START];
				powerDown <= wData[A_PDOWN];
				chanSel <= wData[4:0];
			end else if (wAddr == OFF_CTRL_B) begin
				bandgapEn <= wData[B_BGEN];
				justify <= wData[B_JUST];
				refSel <= wData[B_REF_LSB +: 2];
				divSel <= wData[2:0];
			end else if (wAddr == OFF_PIN_LO) begin
				pinSelLo <= wData[7:0];
			end else if (wAddr == OFF_PIN_HI) begin
				pinSelHi <= wData[7:0];
			end else if (wAddr == OFF_INT) begin
				gie <= wData[I_GIE];
				cie <= wData[I_CIE];
			end
		end
	end

	// ==========================================================
	// Request flag: a completion in the clearing cycle still sets it
	logic flagWrite; // Software writes the flag
	assign flagWrite = wLane0 && (wAddr == OFF_INT);

	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			reqFlag <= 1'b0;
		end else if (convDone) begin
			reqFlag <= 1'b1;
		end else if (flagWrite) begin
			reqFlag <= wData[I_FLAG];
		end
	end

	// Interrupt only with both enables set; else software polls busy
	assign convIrq = reqFlag && gie && cie;

	// ==========================================================
	// Converter clock
	adcc_clk_div uDiv (
		.core_clk(core_clk),
		.nrst(nrst),
		.divSel(divSel),
		.subTick(subTick),
		.convTick(convTick)
	);

	// ==========================================================
	// Sequencer; a powered-down converter makes no progress
	assign convDone = (state == ST_CONV) && convTick && !powerDown &&
		(tickCnt == LAST_TICK);

	always_comb begin
		next_state = state;
		case (state)
			ST_IDLE: begin
				if (startBit) begin
					next_state = ST_HOLD;
				end
			end
			ST_HOLD: begin
				if (!startBit) begin
					next_state = ST_CONV;
				end
			end
			ST_CONV: begin
				// Raising start again aborts and resets
				if (startBit) begin
					next_state = ST_HOLD;
				end else if (convDone) begin
					next_state = ST_IDLE;
				end
			end
			default: begin
				next_state = ST_IDLE;
			end
		endcase
	end

	// State, clock count, busy flag and result capture
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			state <= ST_IDLE;
			tickCnt <= 4'h0;
			busy <= RST_CTRL_A[A_BUSY];
			result <= 12'h000;
		end else begin
			state <= next_state;
			if (state != ST_CONV) begin
				tickCnt <= 4'h0;
			end else if (convTick && !powerDown) begin
				tickCnt <= tickCnt + 4'h1;
			end
			if (startBit) begin
				busy <= 1'b1;
			end else if (convDone) begin
				busy <= 1'b0;
				result <= convData;
			end
		end
	end

	// ==========================================================
	// Analog core controls
	assign anaCtrl.powerDown = powerDown;
	assign anaCtrl.convReset = (state == ST_HOLD);
	assign anaCtrl.sampleEn = (state == ST_CONV) && convTick && !powerDown;
	assign anaCtrl.channel = chanSel;
	assign anaCtrl.extSel = (chanSel[4:3] == 2'b00) ?
		8'(8'h01 << chanSel[2:0]) : 8'h00;
	assign anaCtrl.ampA = (chanSel == CH_AMP_A);
	assign anaCtrl.ampB = (chanSel[4:3] == 2'b01) &&
		(chanSel != CH_AMP_A);
	assign anaCtrl.bandgap = chanSel[4];
	assign anaCtrl.refSel = refSel;
	assign anaCtrl.bandgapEn = bandgapEn;

	// ==========================================================
	// Pin overrides
	logic [15:0] pinSel; // Both select groups
	assign pinSel = {pinSelHi, pinSelLo};
	assign pinCtrl.analog = pinSel;
	assign pinCtrl.pullEff = pullReq & ~pinSel;
	assign pinCtrl.dirEff = portDirCtrl | pinSel;
	assign pinCtrl.vrefPin = (refSel == REF_EXT_PIN);

	// ==========================================================
	// Assertions
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!nrst);

	// Run length kept apart from tickCnt, so the check is independent
	logic [4:0] fastCnt; // Cycles spent in the current conversion
	logic fastRun; // Run so far undivided and powered

	// Only full-rate runs are judged; slower ones may wrap the count
	always_ff @(posedge core_clk) begin
		if (!nrst || (state != ST_CONV)) begin
			fastCnt <= 5'h00;
			fastRun <= 1'b1;
		end else begin
			fastCnt <= fastCnt + 5'h01;
			fastRun <= fastRun && (divSel == 3'h0) && !powerDown;
		end
	end

	a_hold_busy_high: assert property (
		(state == ST_HOLD) |-> busy && anaCtrl.convReset)
		else $error("busy low while converter held in reset");
	a_start_fall_go: assert property (
		(state == ST_HOLD) && !startBit |=> (state == ST_CONV) && busy)
		else $error("start fall did not launch conversion");
	a_done_busy_clr: assert property (
		convDone && !startBit |=> !busy && (state == ST_IDLE))
		else $error("busy not cleared at conversion end");
	a_done_sets_flag: assert property (
		convDone |=> reqFlag)
		else $error("request flag not set at conversion end");
	a_irq_needs_en: assert property (
		convIrq |-> gie && cie && reqFlag)
		else $error("interrupt raised without both enables");
	a_div_undivided: assert property (
		(divSel == 3'h0) |-> convTick)
		else $error("undivided clock missed a cycle");
	a_div_slowest: assert property (
		(divSel == 3'h6) && convTick |=> !convTick [*8])
		else $error("divide by 64 ticked too soon");
	a_pdown_stalls: assert property (
		powerDown && (state == ST_CONV) |=> $stable(tickCnt))
		else $error("conversion advanced while powered down");
	a_conv_sixteen: assert property (
		(state == ST_CONV) && fastRun && (divSel == 3'h0) && !powerDown
		|-> convDone == (fastCnt == {1'b0, LAST_TICK}))
		else $error("conversion did not take sixteen clocks");
	a_result_capture: assert property (
		convDone && !startBit |=> result == $past(convData))
		else $error("result not captured at conversion end");
	a_left_align: assert property (
		!justify |-> resHi == result[11:4] && resLo[3:0] == 4'h0)
		else $error("left alignment wrong");
	a_pin_override: assert property (
		((pinCtrl.pullEff & pinSel) == 16'h0000) &&
		((pinCtrl.dirEff & pinSel) == pinSel))
		else $error("analog pin kept pull-high or output");
	a_vref_pin: assert property (
		pinCtrl.vrefPin == (refSel == REF_EXT_PIN))
		else $error("reference pin role mismatch");
	a_busy_readonly: assert property (
		(state == ST_IDLE) && ($past(state) == ST_IDLE) &&
		!startBit && !$past(startBit)
		|-> $stable(busy))
		else $error("busy changed without hardware cause");

	c_poll_done: cover property (convDone && !cie);
	c_irq_done: cover property (convDone ##1 convIrq);
	c_abort: cover property ((state == ST_CONV) ##1 (state == ST_HOLD));
	c_sub_clock: cover property ((divSel == DIV_SUB) && convDone);

endmodule // adcc_conv_ctrl

// ===== core/adcc_pkg.sv
// Constants, field layouts and carrier types of the converter control block.
// Assumes one 100 MHz clock and an AXI4-Lite master that drives the registers.
//
// Overview of operation
// - Start high then low launches a conversion
// - Start held high resets converter, busy reads one
// - Busy clears by hardware when conversion ends
// - Completion sets request flag, interrupt when enabled
// - Interrupt needs global and converter enables
// - Divider: 000 undivided to 110 /64, 111 sub
// - Power-down bit high switches the converter off
// - Reference code 01 takes shared pin over
// - Analog pins lose functions and pull-high
// - Analog select overrides port direction control
// - Conversion lasts sixteen converter clock periods
// - Result is twelve bits, full scale FFF
// - Channel code picks pin, amplifier or bandgap
// - Justify bit selects left or right alignment
// - Reference code: supply, external pin, internal
package adcc_pkg;

	// ==========================================================
	// Bus geometry
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ==========================================================
	// Register byte offsets
	localparam logic [7:0] OFF_CTRL_A = 8'h00; // converter_control_register_a
	localparam logic [7:0] OFF_CTRL_B = 8'h04; // converter_control_register_b
	localparam logic [7:0] OFF_RES_LO = 8'h08; // result_low_byte
	localparam logic [7:0] OFF_RES_HI = 8'h0C; // result_high_byte
	localparam logic [7:0] OFF_PIN_LO = 8'h10; // pin_select_register_low
	localparam logic [7:0] OFF_PIN_HI = 8'h14; // pin_select_register_high
	localparam logic [7:0] OFF_INT = 8'h18; // interrupt enables and flag

	// ==========================================================
	// Field positions
	localparam int A_START = 7;
	localparam int A_BUSY = 6;
	localparam int A_PDOWN = 5;
	localparam int B_BGEN = 6;
	localparam int B_JUST = 5;
	localparam int B_REF_LSB = 3;
	localparam int I_GIE = 0;
	localparam int I_CIE = 1;
	localparam int I_FLAG = 2;

	// ==========================================================
	// Reset values
	localparam logic [7:0] RST_CTRL_A = 8'h60; // Busy and power-down high
	localparam logic [7:0] RST_CTRL_B = 8'h00;
	localparam logic [7:0] RST_PIN = 8'h00;

	// ==========================================================
	// Codes
	localparam logic [2:0] DIV_SUB = 3'h7;
	localparam logic [1:0] REF_SUPPLY = 2'h0;
	localparam logic [1:0] REF_EXT_PIN = 2'h1;
	localparam logic [4:0] CH_AMP_A = 5'h08;
	localparam int RES_W = 12;
	localparam logic [11:0] RES_FULL = 12'hFFF;

	// ==========================================================
	// Timing
	localparam int SYS_CLK_NS = 10;
	localparam int CONV_TICKS = 16;
	localparam logic [3:0] LAST_TICK = 4'(CONV_TICKS - 1);
	localparam int CONV_CLK_MIN_NS = 500;
	localparam int CONV_CLK_MAX_NS = 10000;
	localparam int CONV_CLK_MIN_CYC =
		(CONV_CLK_MIN_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;
	localparam int CONV_CLK_MAX_CYC = CONV_CLK_MAX_NS / SYS_CLK_NS;

	// ==========================================================
	// Types
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00, // No conversion running
		ST_HOLD = 2'b01, // Start high, converter held in reset
		ST_CONV = 2'b10 // Counting converter clocks
	} adcc_state_e;

	typedef struct packed {
		logic powerDown; // Analog circuitry off
		logic convReset; // Converter held in reset
		logic sampleEn; // One converter clock step
		logic [4:0] channel; // Raw channel code
		logic [7:0] extSel; // One-hot external input
		logic ampA; // First amplifier output
		logic ampB; // Second amplifier output
		logic bandgap; // Bandgap voltage input
		logic [1:0] refSel; // Reference source code
		logic bandgapEn; // Bandgap circuit enable
	} adcc_ana_s;

	typedef struct packed {
		logic [15:0] analog; // Pin taken as analog input
		logic [15:0] pullEff; // Pull-high after override
		logic [15:0] dirEff; // Direction after override, 1 input
		logic vrefPin; // Shared pin in reference role
	} adcc_pin_s;

endpackage

// ===== core/adcc_clk_div.sv
// Converter clock divider: one-cycle enable pulses from the system clock.
// Assumes the sub clock arrives as a synchronous one-cycle tick.
module adcc_clk_div (
	input wire logic core_clk, // System clock
	input wire logic nrst, // Synchronous reset, active low
	input wire logic [2:0] divSel, // Divider code
	input wire logic subTick, // Sub clock tick
	output logic convTick // Converter clock enable
);
	import adcc_pkg::*;

	// ==========================================================
	// Free-running prescaler
	logic [5:0] preCnt; // Prescale counter
	logic [5:0] mask; // Low bits that must be all ones

	// Code n divides by two to the n
	assign mask = 6'((7'h01 << divSel) - 7'h01);
	// Sub code ignores the prescaler entirely
	assign convTick = (divSel == DIV_SUB) ? subTick :
		((preCnt & mask) == mask);

	// Counter wraps every 64 cycles, the longest divide
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			preCnt <= 6'h00;
		end else begin
			preCnt <= preCnt + 6'h01;
		end
	end

endmodule // adcc_clk_div

// ===== test/adcc_conv_ctrl_tb_top.sv
// Self-checking bench for the converter control block.
// Assumes the design package is compiled first; the bench acts as bus master.
module adcc_conv_ctrl_tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	import adcc_pkg::*;

	// ==========================================================
	// Stimulus and observation signals
	logic core_clk, nrst, subTick; // Clock, reset, sub clock tick
	logic [1:0] subDiv; // Sub tick spacing counter
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic s_axi_rvalid, s_axi_rready;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [11:0] convData; // Code offered by the analog core
	logic [15:0] pullReq, portDirCtrl; // Port settings seen by overrides
	adcc_ana_s anaCtrl; // Analog core controls
	adcc_pin_s pinCtrl; // Pin overrides
	logic convIrq; // Interrupt line
	int errorCnt, checked; // Mismatch and comparison counters
	logic [7:0] d; // Read data scratch
	logic [1:0] r, r2; // Response scratch

	// Register table rows: address, write value, strobes, readback, response
	typedef struct packed {
		logic [7:0] a, w;
		logic [3:0] s;
		logic [7:0] e;
		logic [1:0] rsp;
	} adcc_row_s;
	adcc_row_s rows [6] = '{
		'{OFF_CTRL_B, 8'hFF, 4'hF, 8'h7F, RESP_OKAY}, // Bit 7 reads zero
		'{OFF_CTRL_B, 8'h00, 4'hE, 8'h7F, RESP_OKAY}, // Lane 0 off: no effect
		'{OFF_PIN_LO, 8'hA5, 4'hF, 8'hA5, RESP_OKAY},
		'{OFF_PIN_HI, 8'h3C, 4'hF, 8'h3C, RESP_OKAY},
		'{OFF_CTRL_A, 8'h1F, 4'hF, 8'h5F, RESP_OKAY}, // Busy stays one
		'{8'h1C, 8'h55, 4'hF, 8'h00, RESP_SLVERR} // Hole in the map
	};

	// ==========================================================
	// Clock, sub clock tick every fourth cycle, design
	always #5 core_clk = ~core_clk;
	always @(posedge core_clk) begin
		subDiv <= subDiv + 2'h1;
		subTick <= (subDiv == 2'h3);
	end

	adcc_conv_ctrl DUT (.core_clk(core_clk), .nrst(nrst),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready), .subTick(subTick), .convData(convData),
		.pullReq(pullReq), .portDirCtrl(portDirCtrl), .anaCtrl(anaCtrl),
		.pinCtrl(pinCtrl), .convIrq(convIrq));

	// ==========================================================
	// Reporting
	task automatic closeOut;
		$display("Comparisons %0d, mismatches %0d", checked, errorCnt);
		if (errorCnt == 0 && checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			errorCnt++;
			$display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
		end
	endtask

	// ==========================================================
	// Bus master: each channel released at the edge it is taken
	// Response ready stays up, so back-to-back calls never retoggle it
	task automatic wr(input logic [7:0] a, input logic [7:0] w,
		input logic [3:0] s, output logic [1:0] rsp);
		int n;
		bit done;
		done = 0;
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h00_0000, w};
		s_axi_wstrb <= s;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (n = 0; n < 50 && !done; n++) begin
			@(posedge core_clk);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid === 1'b1) begin
				rsp = s_axi_bresp;
				done = 1;
			end
		end
		if (!done) begin
			errorCnt++;
			closeOut();
		end
	endtask

	task automatic rd(input logic [7:0] a, output logic [7:0] v,
		output logic [1:0] rsp);
		int n;
		bit done;
		done = 0;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (n = 0; n < 50 && !done; n++) begin
			@(posedge core_clk);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid === 1'b1) begin
				v = s_axi_rdata[7:0];
				rsp = s_axi_rresp;
				done = 1;
			end
		end
		if (!done) begin
			errorCnt++;
			closeOut();
		end
	endtask

	// ==========================================================
	// One start pulse, optional power-down stall, then result checks
	task automatic runConv(input logic [7:0] cb, input logic [11:0] cd,
		input int lo, input int hi, input logic [7:0] eh, input logic [7:0] el,
		input logic pd);
		int n;
		convData <= cd;
		wr(OFF_CTRL_B, cb, 4'hF, r);
		wr(OFF_INT, 8'h03, 4'hF, r);
		wr(OFF_CTRL_A, 8'h80, 4'hF, r);
		// Hold state is entered at the edge that ends the write
		@(posedge core_clk);
		check(anaCtrl.convReset, 1'b1);
		rd(OFF_CTRL_A, d, r);
		check(d[A_BUSY], 1'b1);
		wr(OFF_CTRL_A, {2'b00, pd, 5'h00}, 4'hF, r);
		if (pd) begin
			// Long enough to finish twice over if the count ran on
			repeat (40) @(posedge core_clk);
			check(anaCtrl.sampleEn, 1'b0);
			rd(OFF_CTRL_A, d, r);
			check(d, 8'h60);
			wr(OFF_CTRL_A, 8'h00, 4'hF, r);
		end
		for (n = 0; n < hi + 40 && convIrq !== 1'b1; n++)
			@(posedge core_clk);
		check(n >= lo && n <= hi, 1'b1);
		rd(OFF_CTRL_A, d, r);
		check(d, 8'h00);
		rd(OFF_INT, d, r);
		check(d, 8'h07);
		rd(OFF_RES_HI, d, r);
		check(d, eh);
		rd(OFF_RES_LO, d, r);
		check(d, el);
	endtask

	// ==========================================================
	// Main sequence
	initial begin
		core_clk = 0; nrst = 0; subTick = 0; subDiv = 2'h0;
		s_axi_awaddr = 8'h00; s_axi_awvalid = 0; s_axi_wdata = '0;
		s_axi_wstrb = 4'h0; s_axi_wvalid = 0; s_axi_bready = 0;
		s_axi_araddr = 8'h00; s_axi_arvalid = 0; s_axi_rready = 0;
		convData = 12'h000; pullReq = 16'hFFFF; portDirCtrl = 16'h00FF;
		errorCnt = 0; checked = 0;
		repeat (4) @(posedge core_clk);
		nrst <= 1'b1;
		@(posedge core_clk);
		// Table rows: write, response, readback
		foreach (rows[i]) begin
			wr(rows[i].a, rows[i].w, rows[i].s, r);
			rd(rows[i].a, d, r2);
			check({r, r2}, {2{rows[i].rsp}});
			if (rows[i].rsp == RESP_OKAY) check(d, rows[i].e);
		end
		check(pinCtrl.analog, 16'h3CA5);
		check(pinCtrl.pullEff, 16'hC35A);
		check(pinCtrl.dirEff, 16'h3CFF);
		check(anaCtrl.powerDown, 1'b0);
		check(anaCtrl.bandgapEn, 1'b1);
		// Every channel code
		for (int i = 0; i < 32; i++) begin
			wr(OFF_CTRL_A, 8'(i), 4'hF, r);
			check(anaCtrl.channel, i[4:0]);
			check(anaCtrl.extSel, (i < 8) ? 8'(1 << i) : 8'h00);
			check({anaCtrl.ampA, anaCtrl.ampB, anaCtrl.bandgap},
				{i == 8, i > 8 && i < 16, i >= 16});
		end
		// Every reference code
		for (int i = 0; i < 4; i++) begin
			wr(OFF_CTRL_B, {3'b000, i[1:0], 3'b000}, 4'hF, r);
			check(anaCtrl.refSel, i[1:0]);
			check(pinCtrl.vrefPin, i == 1);
		end
		// Conversions: undivided, divide by 64, sub clock, stalled
		runConv(8'h00, 12'hABC, 12, 18, 8'hAB, 8'hC0, 1'b0);
		runConv(8'h26, 12'hFFF, 940, 1040, 8'h0F, 8'hFF, 1'b0);
		runConv(8'h07, 12'h5A3, 56, 70, 8'h5A, 8'h30, 1'b0);
		runConv(8'h00, 12'h123, 10, 18, 8'h12, 8'h30, 1'b1);
		// Interrupt needs both enables with the flag set
		for (int i = 0; i < 4; i++) begin
			wr(OFF_INT, {5'h00, 1'b1, i[1:0]}, 4'hF, r);
			check(convIrq, i == 3);
		end
		wr(OFF_INT, 8'h03, 4'hF, r);
		check(convIrq, 1'b0);
		// Second reset while idle, after the interrupt checks, restores power-on values
		nrst <= 1'b0;
		repeat (4) @(posedge core_clk);
		nrst <= 1'b1;
		@(posedge core_clk);
		rd(OFF_CTRL_A, d, r);
		check(d, RST_CTRL_A);
		rd(OFF_CTRL_B, d, r);
		check(d, RST_CTRL_B);
		rd(OFF_PIN_LO, d, r);
		check(d, RST_PIN);
		check({convIrq, anaCtrl.powerDown}, 2'b01);
		closeOut();
	end
endmodule // adcc_conv_ctrl_tb_top
